// file: soh_int.v
/*
 Interrupt source, enable and global summary logic of an overhead terminator, with APB slave.
 Assumes single clock clk; event strobes are one-cycle pulses from logic on the same clock.
*/
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "soh_int_regs.vh"

module soh_int (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_b,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Receive path status and events
	input  wire [7:0]  path_status,
	input  wire [2:0]  remote_defect_bits,
	input  wire        path_remote_error_rollover,
	input  wire        path_parity_rollover,
	// Retiming and transmit events
	input  wire        receive_fifo_overflow,
	input  wire        transmit_fifo_overflow,
	input  wire        tx_bus_parity_error,
	input  wire        tx_negative_justify_rollover,
	input  wire        tx_positive_justify_rollover,
	// Active flags of the five other receive source registers
	input  wire [4:0]  other_source_active,
	// Interrupt and configuration
	output reg         chip_int,
	output reg         receive_retiming_disable
);

	// Access decode, one-wait-state APB: answer one cycle after the access is taken
	wire        acc     = psel & penable & ~pready;
	wire        rd_acc  = acc & ~pwrite;
	wire        wr_acc  = acc & pwrite;
	wire        aligned = (paddr[1:0] == 2'h0);
	wire [7:0]  idx     = paddr[9:2];
	wire        in_map  = aligned & (paddr[11:10] == 2'h0);

	reg  [7:0]  path_src_q;
	reg  [7:0]  path_src_d;
	wire [7:0]  path_en_q;
	reg         retime_src_q;
	reg         retime_src_d;
	wire        retime_en_q;
	reg  [3:0]  tx_src_q;
	reg  [3:0]  tx_src_d;
	wire [3:0]  tx_en_q;
	reg  [1:0]  par_cnt_q;
	reg  [1:0]  par_cnt_d;
	reg  [7:0]  stat_last_q;
	reg  [2:0]  remdef_last_q;

	// Read strobes, and the count-read write strobe, that double as clears
	wire        rd_path_stat = rd_acc & in_map & (idx == `SOH_IDX_PATH_STAT);
	wire        rd_remdef    = rd_acc & in_map & (idx == `SOH_IDX_REMDEF);
	wire        rd_retime    = rd_acc & in_map & (idx == `SOH_IDX_RETIME_SRC);
	wire        rd_tx        = rd_acc & in_map & (idx == `SOH_IDX_TX_SRC);
	wire        wr_cnt_rd    = wr_acc & in_map & (idx == `SOH_IDX_CNT_RD);

	// Write strobes of the enable and configuration registers
	wire        wr_path_en   = wr_acc & in_map & (idx == `SOH_IDX_PATH_EN);
	wire        wr_retime_en = wr_acc & in_map & (idx == `SOH_IDX_RETIME_EN);
	wire        wr_tx_en     = wr_acc & in_map & (idx == `SOH_IDX_TX_EN);
	wire        wr_cfg       = wr_acc & in_map & (idx == `SOH_IDX_RETIME_CFG);

	// Counters live elsewhere; software reports their reads via the count-read register
	// Limitation: a counter read that software forgets to report leaves its rollover bit set
	// Trade-off: one extra write per counter read instead of a port per counter
	wire        rd_rem_cnt   = wr_cnt_rd & pwdata[`SOH_CRD_REM_ERR];
	wire        rd_par_cnt   = wr_cnt_rd & pwdata[`SOH_CRD_PARITY];
	wire        rd_pos_cnt   = wr_cnt_rd & pwdata[`SOH_CRD_TX_POS];
	wire        rd_neg_cnt   = wr_cnt_rd & pwdata[`SOH_CRD_TX_NEG];

	// Change detection against the last sampled values
	wire [7:0]  stat_chg   = (path_status ^ stat_last_q) & `SOH_PATH_STAT_MASK;
	wire        remdef_chg = |(remote_defect_bits ^ remdef_last_q);

	// Enabled source terms
	wire [7:0]  path_act   = path_src_q & path_en_q;
	wire        retime_act = retime_src_q & retime_en_q;
	wire [3:0]  tx_act     = tx_src_q & tx_en_q;

	// Summary flags, one per source register, from enabled bits only
	wire        transmit_summary_flag = |tx_act;
	wire        retiming_summary_flag = retime_act;
	wire        path_summary_flag     = |path_act;
	wire [7:0]  global_sum            = {transmit_summary_flag, retiming_summary_flag,
	                                     path_summary_flag, other_source_active};

	// Path source next value: clears first, then sets override
	always @* begin
		path_src_d = path_src_q;
		// Clearing reads first
		if (rd_path_stat)
			path_src_d = path_src_d & ~`SOH_PATH_STAT_MASK;
		if (rd_remdef)
			path_src_d[3] = 1'b0;
		if (rd_rem_cnt)
			path_src_d[1] = 1'b0;
		if (rd_par_cnt)
			path_src_d[0] = 1'b0;
		// Events last, so a set in the clearing cycle is never lost
		path_src_d = path_src_d | stat_chg;
		if (remdef_chg)
			path_src_d[3] = 1'b1;
		if (path_remote_error_rollover)
			path_src_d[1] = 1'b1;
		if (path_parity_rollover)
			path_src_d[0] = 1'b1;
	end

	// Retiming source; overflow ignored while retiming is disabled
	always @* begin
		retime_src_d = retime_src_q & ~rd_retime;
		if (receive_fifo_overflow & ~receive_retiming_disable)
			retime_src_d = 1'b1;
	end

	// Parity error counter; holds at the limit until the clearing read
	always @* begin
		par_cnt_d = par_cnt_q;
		if (rd_tx)
			par_cnt_d = 2'h0;
		if (tx_bus_parity_error && par_cnt_d != `SOH_TX_PAR_LIMIT)
			par_cnt_d = par_cnt_d + 2'h1;
	end

	// Transmit sources; a parity error in the clearing cycle counts from zero
	always @* begin
		tx_src_d = tx_src_q;
		if (rd_tx)
			tx_src_d[1:0] = 2'h0;
		if (rd_neg_cnt)
			tx_src_d[3] = 1'b0;
		if (rd_pos_cnt)
			tx_src_d[2] = 1'b0;
		if (par_cnt_d == `SOH_TX_PAR_LIMIT)
			tx_src_d[0] = 1'b1;
		if (transmit_fifo_overflow)
			tx_src_d[1] = 1'b1;
		if (tx_negative_justify_rollover)
			tx_src_d[3] = 1'b1;
		if (tx_positive_justify_rollover)
			tx_src_d[2] = 1'b1;
	end

	// Path source flops
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			path_src_q <= `SOH_RST_BYTE;
		else
			path_src_q <= path_src_d;
	end

	// Retiming source flop
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			retime_src_q <= 1'b0;
		else
			retime_src_q <= retime_src_d;
	end

	// Transmit source flops
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			tx_src_q <= 4'h0;
		else
			tx_src_q <= tx_src_d;
	end

	// Parity error counter flops
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			par_cnt_q <= 2'h0;
		else
			par_cnt_q <= par_cnt_d;
	end

	// Status history; reset to zero, so nonzero status in SOH_PATH_STAT_MASK bits after reset counts as a change
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			stat_last_q <= `SOH_RST_BYTE;
		else
			stat_last_q <= path_status;
	end

	// Remote defect history
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			remdef_last_q <= 3'h0;
		else
			remdef_last_q <= remote_defect_bits;
	end

	// Path enables, all eight bits stored
	soh_int_en_reg #(
		.W (8)
	) i_path_en (
		.clk   (clk),
		.rst_b (rst_b),
		.wr    (wr_path_en),
		.d     (pwdata[7:0]),
		.q     (path_en_q)
	);

	// Retiming enable; reserved bits not stored
	soh_int_en_reg #(
		.W (1)
	) i_retime_en (
		.clk   (clk),
		.rst_b (rst_b),
		.wr    (wr_retime_en),
		.d     (pwdata[0:0]),
		.q     (retime_en_q)
	);

	// Transmit enables; reserved bits not stored
	soh_int_en_reg #(
		.W (4)
	) i_tx_en (
		.clk   (clk),
		.rst_b (rst_b),
		.wr    (wr_tx_en),
		.d     (pwdata[3:0]),
		.q     (tx_en_q)
	);

	// Retiming disable configuration bit
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			receive_retiming_disable <= 1'b0;
		else if (wr_cfg)
			receive_retiming_disable <= pwdata[`SOH_RETIME_DSBL_BIT];
	end

	// Read mux; the source registers themselves are read-only
	reg [7:0] rd_byte;
	reg       rd_hit;
	always @* begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		case (idx)
			`SOH_IDX_PATH_SRC:   rd_byte = path_src_q;
			`SOH_IDX_PATH_EN:    rd_byte = path_en_q;
			`SOH_IDX_RETIME_SRC: rd_byte = {7'h00, retime_src_q};
			`SOH_IDX_RETIME_EN:  rd_byte = {7'h00, retime_en_q};
			`SOH_IDX_TX_SRC:     rd_byte = {4'h0, tx_src_q};
			`SOH_IDX_TX_EN:      rd_byte = {4'h0, tx_en_q};
			`SOH_IDX_GLOBAL:     rd_byte = global_sum;
			`SOH_IDX_PATH_STAT:  rd_byte = path_status;
			`SOH_IDX_REMDEF:     rd_byte = {4'h0, remote_defect_bits, 1'b0};
			`SOH_IDX_RETIME_CFG: rd_byte = {4'h0, receive_retiming_disable, 3'h0};
			`SOH_IDX_CNT_RD:     rd_byte = 8'h00;
			default:             rd_hit  = 1'b0;
		endcase
	end

	// Answer terms of the access being taken
	wire        rd_ok   = rd_acc & in_map & rd_hit;
	wire        bad_acc = acc & ~(in_map & rd_hit);
	wire        int_any = |path_act | retime_act | |tx_act;

	// Ready one cycle after the access is taken
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			pready <= 1'b0;
		else
			pready <= acc;
	end

	// Error with ready; refused accesses have no effect
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			pslverr <= 1'b0;
		else
			pslverr <= bad_acc;
	end

	// Read data, zero outside a good read so stale bytes never leak
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			prdata <= 32'h00000000;
		else
			prdata <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
	end

	// Interrupt level, one cycle behind source and enable
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			chip_int <= 1'b0;
		else
			chip_int <= int_any;
	end

endmodule

// Enable register of one source register; bits reset to disabled
module soh_int_en_reg #(
	parameter W = 8
) (
	// Clock and reset
	input  wire         clk,
	input  wire         rst_b,
	// Write strobe and data
	input  wire         wr,
	input  wire [W-1:0] d,
	// Stored enables
	output reg  [W-1:0] q
);

	// Reset to all disabled, load on a write
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			q <= {W{1'b0}};
		else if (wr)
			q <= d;
	end

endmodule

// file: soh_int_asserts.sv
/* Checker for the soh_int APB and config ports.
   Assumes one clock and an active-low async reset. */
`timescale 1ns/100ps
module soh_int_chk (
	// Clock, reset, APB strobes and flags
	input wire logic        clk, rst_b, psel, penable, pwrite, pready, pslverr,
	input wire logic        chip_int, receive_retiming_disable,
	// APB buses
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Request taken, and a config write among them
	wire tk = psel && penable && !pready;
	wire cw = tk && pwrite && paddr == 12'h144;
	a_ready_one_wait: assert property (tk |=> pready) else $error("late ready");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("long ready");
	a_err_unaligned: assert property (tk && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0) else $error("no err");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("stray err");
	a_sum_read_ok: assert property (tk && paddr == 12'h344 |=> !pslverr && prdata[31:8] == 24'h0) else $error("sum");
	a_cfg_write: assert property (cw |=> receive_retiming_disable == $past(pwdata[3])) else $error("cfg");
	a_cfg_hold: assert property (!cw |=> $stable(receive_retiming_disable)) else $error("cfg moved");
	a_int_reset_low: assert property ($rose(rst_b) |-> !chip_int) else $error("int");
	// Main scenarios
	c_cfg: cover property (cw);
	c_err: cover property (pslverr);
	c_int: cover property ($rose(chip_int));
endmodule

bind soh_int soh_int_chk i_chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .pslverr(pslverr), .chip_int(chip_int), .receive_retiming_disable(receive_retiming_disable),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata));

// file: soh_int_regs.vh
/*
 Register map, field positions and reset values of the overhead interrupt source block.
 Assumes byte offsets on APB with 32-bit data; 8-bit registers in the low bits.
*/
`ifndef SOH_INT_REGS_VH
`define SOH_INT_REGS_VH

// Register offsets (printed offsets are not all multiples of four: these are indices)
`define SOH_IDX_SUM_RG      8'hA0
`define SOH_IDX_SUM_RGMUX   8'hA1
`define SOH_IDX_SUM_MUX     8'hA2
`define SOH_IDX_SUM_PROT    8'hA3
`define SOH_IDX_SUM_AHPT    8'hA4
`define SOH_IDX_PATH_SRC    8'hA5
`define SOH_IDX_RETIME_SRC  8'hA6
`define SOH_IDX_PATH_EN     8'hB5
`define SOH_IDX_RETIME_EN   8'hB6
`define SOH_IDX_PATH_STAT   8'hC5
`define SOH_IDX_REMDEF      8'h85
`define SOH_IDX_RETIME_CFG  8'h51
`define SOH_IDX_GLOBAL      8'hD1
`define SOH_IDX_TX_SRC      8'hE0
`define SOH_IDX_TX_EN       8'hE1
`define SOH_IDX_CNT_RD      8'hF0
`define SOH_IDX_OTHER_SRC   8'hF1

// Field positions
`define SOH_RETIME_DSBL_BIT 3
`define SOH_REMDEF_LO       1
`define SOH_REMDEF_HI       3
`define SOH_PATH_STAT_MASK  8'hF4
`define SOH_RETIME_MASK     8'h01
`define SOH_TX_MASK         8'h0F

// Counter read strobes in the count-read register
`define SOH_CRD_REM_ERR     0
`define SOH_CRD_PARITY      1
`define SOH_CRD_TX_POS      2
`define SOH_CRD_TX_NEG      3

// Reset values and limits
`define SOH_RST_BYTE        8'h00
`define SOH_TX_PAR_LIMIT    2'h3

`endif

// file: test_soh_int.sv
/* Self-checking bench for soh_int.
   Assumes soh_int and its checker are compiled first. */
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t %h/%h", $time, a, b); end end
module test_soh_int;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, chip_int, rtd, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  r, q, p;
	logic [7:0]  ids [7] = '{8'hA5, 8'hA6, 8'hE0, 8'hD1, 8'hB5, 8'hB6, 8'hE1};
	logic [2:0]  rdb;
	logic [6:0]  evt;
	logic [4:0]  oth;
	int          fails, n_compared;
	soh_int i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .path_status(q),
		.remote_defect_bits(rdb), .path_remote_error_rollover(evt[0]), .path_parity_rollover(evt[1]),
		.receive_fifo_overflow(evt[2]), .transmit_fifo_overflow(evt[3]), .tx_bus_parity_error(evt[4]),
		.tx_negative_justify_rollover(evt[5]), .tx_positive_justify_rollover(evt[6]),
		.other_source_active(oth), .chip_int(chip_int), .receive_retiming_disable(rtd));
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Summary byte with every enable set
	function automatic logic [7:0] glob(input logic [7:0] tx, rt, pa, input logic [4:0] o);
		return {|tx, |rt, |pa, o};
	endfunction
	// One APB transfer; bounded wait for pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			tally_and_finish();
		end
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rc(input logic [7:0] idx, input logic [7:0] e);
		apb(1'b0, {2'h0, idx, 2'h0}, 8'h00);
		`CHK(rd, {24'h0, e})
	endtask
	// One-cycle event strobe
	task automatic pulse(input logic [6:0] m);
		@(posedge clk);
		evt <= m;
		@(posedge clk);
		evt <= 7'h00;
	endtask
	task automatic tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog, far beyond the few hundred cycles needed
	initial begin
		#200000;
		fails++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(5729));
		{psel, penable, pwrite, paddr, pwdata, q, rdb, evt, oth} = '0;
		rst_b = 1'b0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		foreach (ids[i]) rc(ids[i], 8'h00);
		// Masked status change stays off the pin
		r = $urandom | 8'h04;
		q <= r;
		repeat (3) @(posedge clk);
		`CHK(chip_int, 1'b0)
		rc(8'hD1, 8'h00);
		apb(1'b1, 12'h2D4, 8'hFF);
		apb(1'b1, 12'h2D8, 8'h01);
		apb(1'b1, 12'h384, 8'h0F);
		`CHK(chip_int, 1'b1)
		rc(8'hD1, glob(0, 0, r, 0));
		// Random status changes, cleared by the status read
		p = 8'h00;
		repeat (6) begin
			rc(8'hA5, (r ^ p) & 8'hF4);
			apb(1'b0, 12'h314, 8'h00);
			rc(8'hA5, 8'h00);
			p = r;
			r = $urandom;
			q <= r;
		end
		rc(8'hA5, (r ^ p) & 8'hF4);
		apb(1'b0, 12'h314, 8'h00);
		rdb <= 3'h1 + 3'($urandom % 7);
		rc(8'hA5, 8'h08);
		apb(1'b0, 12'h214, 8'h00);
		rc(8'hA5, 8'h00);
		pulse(7'h03);
		rc(8'hA5, 8'h03);
		apb(1'b1, 12'h3C0, 8'h01);
		rc(8'hA5, 8'h01);
		pulse(7'h04);
		rc(8'hA6, 8'h01);
		rc(8'hA6, 8'h00);
		apb(1'b1, 12'h144, 8'h08);
		`CHK(rtd, 1'b1)
		pulse(7'h04);
		rc(8'hA6, 8'h00);
		// Parity count is cleared by the read, so two plus two never fires
		repeat (2) pulse(7'h10);
		rc(8'hE0, 8'h00);
		repeat (2) pulse(7'h10);
		rc(8'hE0, 8'h00);
		repeat (2) pulse(7'h10);
		pulse(7'h18);
		rc(8'hE0, 8'h03);
		pulse(7'h60);
		r = $urandom;
		oth <= r[4:0];
		rc(8'hE0, 8'h0C);
		rc(8'hD1, glob(8'h0C, 0, 8'h01, r[4:0]));
		apb(1'b1, 12'h3C0, 8'h0E);
		rc(8'hE0, 8'h00);
		apb(1'b0, 12'h295, 8'h00);
		`CHK(er, 1'b1)
		apb(1'b1, 12'h298, 8'hFF);
		rc(8'hA6, 8'h00);
		tally_and_finish();
	end
endmodule
